//--- rtl/sei_device.sv
`include "sei_regs.svh"
`default_nettype none

// Notes on behaviour
// - First one after select rise starts command
// - Leading zeros before start bit ignored
// - Address and data shifted MSB first
// - Read: start, 10, address, then data
// - Write: start, 01, address, sixteen data
// - Erase: start, 11, address, no data
// - Opcode 00: top address bits pick operation
// - Dummy zero on last address bit, then word
// - Read continues at incremented addresses
// - Write programs when select falls after data
// - Busy rejects commands, shown low on output
// - Write-all programs every word at once
// - Old contents replaced by the new value in one step when programming
// - Power-up leaves writes disabled
// - Enable persists; reads work whenever not busy
// - Disable refuses writes again, reads still work
// - Host should disable writes when finished
// - Host clocks all don't-care address bits
// - Erase sets word to ones on select fall
// - Erase-all sets all words to ones
// - Input sampled and output updated on rise
// - Status shown while selected after a program, until start bit
// - Host drops select after every command
module sei_device
  import sei_pkg::*;
#(
  parameter int PROG_CYCLES = `SEI_PROGRAM_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  sei_if.device link,
  output logic busy,
  output logic write_enabled
);
  localparam int AW = `SEI_ADDR_W;
  localparam int WW = `SEI_WORD_W;
  localparam logic [3:0] OP_LAST = 4'(`SEI_OPC_W - 1);
  localparam logic [3:0] ADDR_LAST = 4'(`SEI_ADDR_W - 1);
  localparam logic [3:0] WORD_LAST = 4'(`SEI_WORD_W - 1);

  // Link domain, clocked by the serial clock
  sei_link_t lstate;        // Parser state
  sei_link_t next_lstate;   // State after the last address bit
  logic [3:0] bit_cnt;      // Bit position inside the current field
  logic started;            // Start bit seen in this selection
  sei_op_t op_sh;           // Opcode shift register
  logic [AW-1:0] addr_sh;   // Address shift register
  logic [AW-1:0] addr_full; // Address including the bit now sampled
  logic [WW-1:0] data_sh;   // Write data shift register
  logic [WW-1:0] rd_sh;     // Read word being shifted out
  logic [AW-1:0] rd_addr;   // Next address to fetch during a read
  logic reading;            // Output carries read data
  logic out_bit;            // Registered read output bit
  logic cmd_last;           // Last bit of a non-read command sampled
  logic cmd_tog;            // Toggles once per completed non-read command
  logic busy_l1;            // Busy synchroniser, first stage
  logic busy_l2;            // Busy synchroniser, second stage

  // System domain
  logic cs_s1, cs_s2;       // Chip select synchroniser
  logic tog_s1, tog_s2;     // Command toggle synchroniser
  logic st_s1, st_s2;       // Start-bit synchroniser
  logic seen;               // Last command toggle taken over
  logic armed;              // Command waiting for select to fall
  logic exec;               // Command executes this cycle
  logic want_prog;          // Command is a programming command
  logic prog_go;            // Programming starts this cycle
  logic bulk;               // Programming hits every word
  logic [WW-1:0] wdata;     // Value to program
  sei_ext_t ext_sel;        // Selector under opcode 00
  logic status_armed;       // Status output allowed after a program
  logic [WW-1:0] mem [`SEI_WORDS]; // Word array

  assign addr_full = {addr_sh[AW-2:0], link.serial_data_in};
  assign ext_sel = sei_ext_t'(addr_sh[`SEI_EXT_POS +: 2]);

  // Decision taken on the last address bit
  always_comb begin
    next_lstate = lk_done;
    if (op_sh == sei_op_read) begin
      next_lstate = lk_read;
    end else if (op_sh == sei_op_write) begin
      next_lstate = lk_data;
    end else if (op_sh == sei_op_ext && addr_full[AW-1 -: 2] == write_all_cmd) begin
      next_lstate = lk_data;
    end
  end

  // Parser; select low is the internal reset of the sequence
  always_ff @(posedge link.serial_clock_in or negedge link.chip_select) begin
    if (!link.chip_select) begin
      lstate <= lk_wait;
      bit_cnt <= 4'h0;
      started <= 1'b0;
    end else begin
      unique case (lstate)
        // Zeros are skipped; the first one is the start bit
        lk_wait: begin
          if (link.serial_data_in) begin
            started <= 1'b1;
            bit_cnt <= 4'h0;
            lstate <= busy_l2 ? lk_done : lk_opcode;
          end
        end
        // Two opcode bits
        lk_opcode: begin
          bit_cnt <= (bit_cnt == OP_LAST) ? 4'h0 : bit_cnt + 4'h1;
          if (bit_cnt == OP_LAST) begin
            lstate <= lk_addr;
          end
        end
        // Address bits, all of them even when don't-care
        lk_addr: begin
          bit_cnt <= (bit_cnt == ADDR_LAST) ? 4'h0 : bit_cnt + 4'h1;
          if (bit_cnt == ADDR_LAST) begin
            lstate <= next_lstate;
          end
        end
        // Sixteen data bits
        lk_data: begin
          bit_cnt <= (bit_cnt == WORD_LAST) ? 4'h0 : bit_cnt + 4'h1;
          if (bit_cnt == WORD_LAST) begin
            lstate <= lk_done;
          end
        end
        // Read streams for as long as the host clocks
        lk_read: begin
          bit_cnt <= (bit_cnt == WORD_LAST) ? 4'h0 : bit_cnt + 4'h1;
        end
        // Extra clocks are ignored until select falls
        lk_done: begin
          lstate <= lk_done;
        end
        default: begin
          lstate <= lk_wait;
        end
      endcase
    end
  end

  // Field shift registers, held after the command so the system side reads them
  always_ff @(posedge link.serial_clock_in) begin
    if (lstate == lk_opcode) begin
      op_sh <= sei_op_t'({op_sh[0], link.serial_data_in});
    end
    if (lstate == lk_addr) begin
      addr_sh <= addr_full;
    end
    if (lstate == lk_data) begin
      data_sh <= {data_sh[WW-2:0], link.serial_data_in};
    end
  end

  assign cmd_last = (lstate == lk_addr && bit_cnt == ADDR_LAST && next_lstate == lk_done)
                 || (lstate == lk_data && bit_cnt == WORD_LAST);

  // Event crossing: one toggle per finished non-read command
  always_ff @(posedge link.serial_clock_in or negedge nrst) begin
    if (!nrst) begin
      cmd_tog <= 1'b0;
    end else if (cmd_last) begin
      cmd_tog <= ~cmd_tog;
    end
  end

  // Busy brought into the link domain
  always_ff @(posedge link.serial_clock_in or negedge nrst) begin
    if (!nrst) begin
      busy_l1 <= 1'b0;
      busy_l2 <= 1'b0;
    end else begin
      busy_l1 <= busy;
      busy_l2 <= busy_l1;
    end
  end

  // Read output; the array is only written while busy, when reads are refused
  always_ff @(posedge link.serial_clock_in or negedge link.chip_select) begin
    if (!link.chip_select) begin
      reading <= 1'b0;
      out_bit <= 1'b0;
      rd_sh <= 16'h0000;
      rd_addr <= '0;
    end else if (lstate == lk_addr && bit_cnt == ADDR_LAST && next_lstate == lk_read) begin
      reading <= 1'b1;
      out_bit <= 1'b0;
      rd_sh <= mem[addr_full];
      rd_addr <= addr_full + 1'b1;
    end else if (lstate == lk_read) begin
      out_bit <= rd_sh[WW-1];
      if (bit_cnt == WORD_LAST) begin
        rd_sh <= mem[rd_addr];
        rd_addr <= rd_addr + 1'b1;
      end else begin
        rd_sh <= {rd_sh[WW-2:0], 1'b0};
      end
    end
  end

  // Synchronisers for select, command toggle and start flag
  always_ff @(posedge clock) begin
    if (!nrst) begin
      {cs_s1, cs_s2, tog_s1, tog_s2, st_s1, st_s2} <= 6'h00;
    end else begin
      cs_s1 <= link.chip_select;
      cs_s2 <= cs_s1;
      tog_s1 <= cmd_tog;
      tog_s2 <= tog_s1;
      st_s1 <= started;
      st_s2 <= st_s1;
    end
  end

  // A new command waits for select to fall; one arriving while busy is dropped
  always_ff @(posedge clock) begin
    if (!nrst) begin
      seen <= 1'b0;
      armed <= 1'b0;
    end else begin
      if (exec) begin
        armed <= 1'b0;
      end
      if (tog_s2 != seen) begin
        seen <= tog_s2;
        armed <= !busy;
      end
    end
  end

  assign exec = armed && !cs_s2 && !busy;
  assign bulk = (op_sh == sei_op_ext);
  assign want_prog = (op_sh == sei_op_write) || (op_sh == sei_op_erase)
                  || (bulk && (ext_sel == write_all_cmd || ext_sel == erase_all_cmd));
  assign prog_go = exec && want_prog && write_enabled;
  assign wdata = (op_sh == sei_op_write || (bulk && ext_sel == write_all_cmd)) ? data_sh : `SEI_ERASED;

  // Write-enable latch, disabled from reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      write_enabled <= 1'b0;
    end else if (exec && bulk && ext_sel == write_enable_cmd) begin
      write_enabled <= 1'b1;
    end else if (exec && bulk && ext_sel == write_disable_cmd) begin
      write_enabled <= 1'b0;
    end
  end

  // Self-timed programming period
  sei_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .clock(clock),
    .nrst(nrst),
    .start(prog_go),
    .busy(busy)
  );

  // Status shown after a program until the next start bit
  always_ff @(posedge clock) begin
    if (!nrst) begin
      status_armed <= 1'b0;
    end else if (prog_go) begin
      status_armed <= 1'b1;
    end else if (st_s2) begin
      status_armed <= 1'b0;
    end
  end

  // Array words; the new value replaces the old one in one step
  for (genvar i = 0; i < `SEI_WORDS; i++) begin : g_word
    always_ff @(posedge clock) begin
      if (!nrst) begin
        mem[i] <= `SEI_ERASED;
      end else if (prog_go && (bulk || addr_sh == AW'(i))) begin
        mem[i] <= wdata;
      end
    end
  end

  // Output pin: read data, else ready high / busy low, floating when deselected
  assign link.serial_data_out = reading ? out_bit : ~busy;
  assign link.serial_data_out_oe = link.chip_select
                                && (reading || (status_armed && !started));
endmodule

`default_nettype wire

//--- rtl/sei_regs.svh
`ifndef SEI_REGS_SVH
`define SEI_REGS_SVH

// Array shape: 256 words of 16 bits, 8 address bits
`define SEI_ADDR_W 8
`define SEI_WORD_W 16
`define SEI_WORDS 256
// Opcode width and position of the two-bit selector used by opcode 00
`define SEI_OPC_W 2
`define SEI_EXT_POS (`SEI_ADDR_W - 2)
// Longest command frame: start bit, opcode, address, data
`define SEI_FRAME_W (1 + `SEI_OPC_W + `SEI_ADDR_W + `SEI_WORD_W)
`define SEI_SHORT_W (1 + `SEI_OPC_W + `SEI_ADDR_W)
// Value of an erased word
`define SEI_ERASED 16'hffff
// System clock period
`define SEI_CLOCK_PERIOD_NS 40
// Self-timed programming, longest time, rounded down to cycles
`define SEI_PROGRAM_CYCLE_TIME_NS 5000000
`define SEI_PROGRAM_CYCLES (`SEI_PROGRAM_CYCLE_TIME_NS / `SEI_CLOCK_PERIOD_NS)
// Chip select low time, least time, rounded up to cycles
`define SEI_CS_LOW_TIME_NS 200
`define SEI_CS_LOW_CYCLES ((`SEI_CS_LOW_TIME_NS + `SEI_CLOCK_PERIOD_NS - 1) / `SEI_CLOCK_PERIOD_NS)
// Status output settle after chip select rise, plus two synchroniser stages
`define SEI_STATUS_TIME_NS 150
`define SEI_STATUS_CYCLES (((`SEI_STATUS_TIME_NS + `SEI_CLOCK_PERIOD_NS - 1) / `SEI_CLOCK_PERIOD_NS) + 2)
// Host serial clock half period in system clocks
`define SEI_SK_HALF_CYCLES 4

`endif

//--- rtl/sei_pkg.sv
`default_nettype none

package sei_pkg;

  // Two-bit opcode following the start bit
  typedef enum logic [1:0] {
    sei_op_ext = 2'h0,
    sei_op_write = 2'h1,
    sei_op_read = 2'h2,
    sei_op_erase = 2'h3
  } sei_op_t;

  // Selector in the two top address bits under opcode 00
  typedef enum logic [1:0] {
    write_disable_cmd = 2'h0,
    write_all_cmd = 2'h1,
    erase_all_cmd = 2'h2,
    write_enable_cmd = 2'h3
  } sei_ext_t;

  // Commands accepted on the host's user port
  typedef enum logic [2:0] {
    cmd_read = 3'h0,
    cmd_write = 3'h1,
    cmd_erase = 3'h2,
    cmd_write_enable = 3'h3,
    cmd_write_disable = 3'h4,
    cmd_write_all = 3'h5,
    cmd_erase_all = 3'h6
  } sei_cmd_t;

  // Device link parser states
  typedef enum logic [2:0] {
    lk_wait = 3'h0,
    lk_opcode = 3'h1,
    lk_addr = 3'h3,
    lk_data = 3'h2,
    lk_read = 3'h6,
    lk_done = 3'h7
  } sei_link_t;

  // Host sequencer states
  typedef enum logic [2:0] {
    hs_idle = 3'h0,
    hs_shift = 3'h1,
    hs_read = 3'h3,
    hs_gap = 3'h2,
    hs_poll = 3'h6
  } sei_host_t;

endpackage

`default_nettype wire

//--- rtl/sei_if.sv
`default_nettype none

interface sei_if;
  logic chip_select;        // Host selects the device, active high
  logic serial_clock_in;    // Serial clock made by the host
  logic serial_data_in;     // Host to device data
  logic serial_data_out;    // Device output value
  logic serial_data_out_oe; // Device drives its output
  wire logic serial_data_line; // Resolved output wire, pulled up when floating

  // Pull-up keeps a floating output high
  assign serial_data_line = serial_data_out_oe ? serial_data_out : 1'b1;

  modport device (
    input chip_select,
    input serial_clock_in,
    input serial_data_in,
    output serial_data_out,
    output serial_data_out_oe
  );

  modport host (
    output chip_select,
    output serial_clock_in,
    output serial_data_in,
    input serial_data_line
  );
endinterface

`default_nettype wire

//--- rtl/sei_prog_timer.sv
`include "sei_regs.svh"
`default_nettype none

module sei_prog_timer #(
  parameter int CYCLES = `SEI_PROGRAM_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic start,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] remain; // Cycles left in the programming period

  // Loads the full period on start, then counts down to idle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      remain <= '0;
    end else if (start) begin
      remain <= CW'(CYCLES);
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  // Busy while any cycles remain
  assign busy = (remain != '0);
endmodule

`default_nettype wire

//--- rtl/sei_host.sv
`include "sei_regs.svh"
`default_nettype none

module sei_host
  import sei_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  sei_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sei_cmd_t cmd_op,
  input wire logic [`SEI_ADDR_W-1:0] cmd_addr,
  input wire logic [`SEI_WORD_W-1:0] cmd_data,
  input wire logic [3:0] cmd_words,
  input wire logic auto_lock,
  output logic rsp_valid,
  output logic [`SEI_WORD_W-1:0] rsp_data,
  output logic done
);
  localparam int FW = `SEI_FRAME_W;
  localparam int AW = `SEI_ADDR_W;
  localparam logic [2:0] HALF_LAST = 3'(`SEI_SK_HALF_CYCLES - 1);
  localparam logic [3:0] GAP_LAST = 4'(`SEI_CS_LOW_CYCLES - 1);
  localparam logic [3:0] POLL_LAST = 4'(`SEI_STATUS_CYCLES - 1);

  sei_host_t hstate;        // Sequencer state
  logic [2:0] div;          // Serial clock divider
  logic tick;               // Half period elapsed
  logic sk;                 // Serial clock register
  logic cs;                 // Chip select register
  logic [FW-1:0] frame;     // Outgoing bits, MSB first
  logic [4:0] bits_left;    // Frame bits still to clock
  logic prog;               // Command needs a busy poll
  logic rd_cmd;             // Current frame is a read, select stays high after it
  logic lock_pend;          // Write disable to follow
  logic rd_first;           // Next sample is the dummy bit
  logic [3:0] rbit;         // Bit index inside a read word
  logic [3:0] words_left;   // Read words still to collect
  logic [3:0] wait_cnt;     // Gap and poll settle counter
  logic [`SEI_WORD_W-1:0] rsh; // Read word shift register
  logic do_s1, do_s2;       // Output line synchroniser

  // Builds a frame left-justified: start bit, opcode, address, data
  function automatic logic [FW-1:0] build(input sei_op_t op, input logic [AW-1:0] a,
                                          input logic [`SEI_WORD_W-1:0] d);
    build = {1'b1, op, a, d};
  endfunction

  assign tick = (div == HALF_LAST);
  assign cmd_ready = (hstate == hs_idle);
  assign link.chip_select = cs;
  assign link.serial_clock_in = sk;
  assign link.serial_data_in = (hstate == hs_shift) && frame[FW-1];

  // Output line synchroniser
  always_ff @(posedge clock) begin
    if (!nrst) begin
      do_s1 <= 1'b0;
      do_s2 <= 1'b0;
    end else begin
      do_s1 <= link.serial_data_line;
      do_s2 <= do_s1;
    end
  end

  // Divider for the serial clock, running only while clocking
  always_ff @(posedge clock) begin
    if (!nrst || hstate == hs_idle || hstate == hs_gap || hstate == hs_poll) begin
      div <= 3'h0;
    end else begin
      div <= tick ? 3'h0 : div + 3'h1;
    end
  end

  // Sequencer: frame out, read words in, select gap, status poll
  always_ff @(posedge clock) begin
    if (!nrst) begin
      hstate <= hs_idle;
      {cs, sk, prog, rd_cmd, lock_pend, rd_first, rsp_valid, done} <= 8'h00;
      frame <= '0;
      bits_left <= 5'h00;
      rbit <= 4'h0;
      words_left <= 4'h0;
      wait_cnt <= 4'h0;
      rsh <= 16'h0000;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      done <= 1'b0;
      unique case (hstate)
        // Take a command and map it onto a frame
        hs_idle: begin
          if (cmd_valid) begin
            cs <= 1'b1;
            prog <= 1'b0;
            rd_cmd <= (cmd_op == cmd_read);
            bits_left <= 5'(`SEI_SHORT_W);
            words_left <= (cmd_words == 4'h0) ? 4'h1 : cmd_words;
            unique case (cmd_op)
              cmd_read: frame <= build(sei_op_read, cmd_addr, '0);
              cmd_write: begin
                frame <= build(sei_op_write, cmd_addr, cmd_data);
                bits_left <= 5'(FW);
                prog <= 1'b1;
              end
              cmd_erase: begin
                frame <= build(sei_op_erase, cmd_addr, '0);
                prog <= 1'b1;
              end
              cmd_write_all: begin
                frame <= build(sei_op_ext, {write_all_cmd, 6'h00}, cmd_data);
                bits_left <= 5'(FW);
                prog <= 1'b1;
              end
              cmd_erase_all: begin
                frame <= build(sei_op_ext, {erase_all_cmd, 6'h00}, '0);
                prog <= 1'b1;
              end
              cmd_write_enable: frame <= build(sei_op_ext, {write_enable_cmd, 6'h00}, '0);
              default: frame <= build(sei_op_ext, {write_disable_cmd, 6'h00}, '0);
            endcase
            lock_pend <= auto_lock && (cmd_op == cmd_write || cmd_op == cmd_erase
                         || cmd_op == cmd_write_all || cmd_op == cmd_erase_all);
            hstate <= hs_shift;
          end
        end
        // Every frame bit, don't-care address bits included, gets a rise
        hs_shift: begin
          if (tick && !sk) begin
            sk <= 1'b1;
            bits_left <= bits_left - 5'h01;
          end else if (tick) begin
            sk <= 1'b0;
            frame <= {frame[FW-2:0], 1'b0};
            if (bits_left == 5'h00) begin
              rd_first <= 1'b1;
              rbit <= 4'h0;
              cs <= rd_cmd;
              hstate <= rd_cmd ? hs_read : hs_gap;
            end
          end
        end
        // Each rise samples the bit put out on the previous rise
        hs_read: begin
          if (tick && !sk) begin
            sk <= 1'b1;
            if (rd_first) begin
              rd_first <= 1'b0;
            end else begin
              rsh <= {rsh[14:0], do_s2};
              rbit <= rbit + 4'h1;
              if (rbit == 4'hf) begin
                rsp_valid <= 1'b1;
                rsp_data <= {rsh[14:0], do_s2};
                words_left <= words_left - 4'h1;
                if (words_left == 4'h1) begin
                  cs <= 1'b0;
                  sk <= 1'b0;
                  hstate <= hs_gap;
                end
              end
            end
          end else if (tick) begin
            sk <= 1'b0;
          end
        end
        // Select low between commands
        hs_gap: begin
          cs <= 1'b0;
          wait_cnt <= wait_cnt + 4'h1;
          if (wait_cnt == GAP_LAST) begin
            wait_cnt <= 4'h0;
            if (prog) begin
              prog <= 1'b0;
              cs <= 1'b1;
              hstate <= hs_poll;
            end else if (lock_pend) begin
              lock_pend <= 1'b0;
              rd_cmd <= 1'b0;
              cs <= 1'b1;
              frame <= build(sei_op_ext, {write_disable_cmd, 6'h00}, '0);
              bits_left <= 5'(`SEI_SHORT_W);
              hstate <= hs_shift;
            end else begin
              done <= 1'b1;
              hstate <= hs_idle;
            end
          end
        end
        // Wait for the ready level with the clock and data held low
        hs_poll: begin
          if (wait_cnt != POLL_LAST) begin
            wait_cnt <= wait_cnt + 4'h1;
          end else if (do_s2) begin
            wait_cnt <= 4'h0;
            cs <= 1'b0;
            hstate <= hs_gap;
          end
        end
        default: begin
          hstate <= hs_idle;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

//--- tb/sei_props.sv
`default_nettype none

module sei_props (
  input wire logic clock,
  input wire logic nrst,
  input wire logic chip_select,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic serial_data_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // The host makes every link pin from clock, so clock samples them all
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_FLOAT: assert property (!chip_select |-> !serial_data_out_oe)
    else $error("output driven while deselected");
  AST_SK_HIGH: assert property ($rose(serial_clock_in) |->
    serial_clock_in[*4] ##1 !serial_clock_in) else $error("serial clock high time wrong");
  AST_SK_LOW: assert property ($fell(serial_clock_in) |-> !serial_clock_in[*4])
    else $error("serial clock low time short");
  AST_DI_EDGE: assert property (chip_select && $past(chip_select) &&
    $changed(serial_data_in) |-> $fell(serial_clock_in)) else $error("data moved off fall");
  AST_DI_RISE: assert property ($rose(serial_clock_in) |-> $stable(serial_data_in))
    else $error("data moved at rise");
  AST_SK_SEL: assert property (serial_clock_in |-> chip_select)
    else $error("serial clock outside frame");
  AST_CS_GAP: assert property ($fell(chip_select) |-> !chip_select[*5])
    else $error("select low time short");
  AST_CS_SETUP: assert property ($rose(chip_select) |-> !serial_clock_in[*4])
    else $error("serial clock high at select rise");
endmodule

`default_nettype wire

//--- tb/sei_tb.sv
`default_nettype none

module sei_tb
  import sei_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // One table row: command, address, data, expected word or busy flag
  typedef struct packed {sei_cmd_t op; logic [7:0] a; logic [15:0] d; logic [15:0] e;} sei_row_t;
  logic clock = 0, nrst = 1, cmd_valid = 0, auto_lock = 0, seen_busy = 0;
  logic cmd_ready, rsp_valid, done, busy, write_enabled;
  sei_cmd_t cmd_op = cmd_read;
  logic [7:0] cmd_addr = 8'h00;
  logic [15:0] cmd_data = 16'h0000, rsp_data;
  logic [3:0] cmd_words = 4'h0;
  logic [15:0] got[$]; // Words returned by the last command
  int n_fail = 0, checks = 0, cyc = 0;
  sei_row_t rows[12] = '{
    '{cmd_read, 8'h05, 16'h0000, 16'hffff}, '{cmd_write, 8'h05, 16'h1234, 16'h0000},
    '{cmd_write_enable, 8'h00, 16'h0000, 16'h0000}, '{cmd_write, 8'h05, 16'ha5c3, 16'h0001},
    '{cmd_read, 8'h05, 16'h0000, 16'ha5c3}, '{cmd_erase, 8'h05, 16'h0000, 16'h0001},
    '{cmd_read, 8'h05, 16'h0000, 16'hffff}, '{cmd_write_all, 8'h00, 16'h0f0f, 16'h0001},
    '{cmd_read, 8'h9c, 16'h0000, 16'h0f0f}, '{cmd_erase_all, 8'h00, 16'h0000, 16'h0001},
    '{cmd_read, 8'h9c, 16'h0000, 16'hffff}, '{cmd_write, 8'hff, 16'h8001, 16'h0001}};
  sei_if lk();
  sei_host i_sei_host (.clock, .nrst, .link(lk.host), .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_addr, .cmd_data, .cmd_words, .auto_lock, .rsp_valid, .rsp_data, .done);
  sei_device #(.PROG_CYCLES(50)) i_sei_device (.clock, .nrst, .link(lk.device), .busy,
    .write_enabled);
  sei_props i_sei_props (.clock, .nrst, .chip_select(lk.chip_select),
    .serial_clock_in(lk.serial_clock_in), .serial_data_in(lk.serial_data_in),
    .serial_data_out(lk.serial_data_out), .serial_data_out_oe(lk.serial_data_out_oe),
    .serial_data_line(lk.serial_data_line));
  initial forever #20 clock = ~clock;
  // Gather read words and busy at the falling edge, where they are settled
  always @(negedge clock) begin
    if (rsp_valid === 1'b1) got.push_back(rsp_data);
    if (busy === 1'b1) seen_busy = 1'b1;
  end
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      end_sim();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One command through the user port, then wait for done
  task run(input sei_cmd_t op, input logic [7:0] a, input logic [15:0] d, input logic [3:0] w);
    int t;
    got.delete();
    seen_busy = 1'b0;
    @(posedge clock);
    #1 {cmd_op, cmd_addr, cmd_data, cmd_words, cmd_valid} = {op, a, d, w, 1'b1};
    t = 0;
    do begin
      @(posedge clock);
      #1 cmd_valid = 1'b0;
      t++;
    end while (done !== 1'b1 && t < 3000);
    chk({15'h0, done}, 16'h0001, "done");
  endtask
  task end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    // A real falling edge clears the link-side flops, which have no clock yet
    #1 nrst = 1'b0;
    repeat (6) @(posedge clock);
    #1 nrst = 1'b1;
    chk({14'h0, busy, write_enabled}, 16'h0000, "reset");
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].a, rows[i].d, 4'h0);
      if (rows[i].op == cmd_read) begin
        chk(16'(got.size()), 16'h0001, "words");
        chk(got[0], rows[i].e, "word");
      end else if (rows[i].op != cmd_write_enable)
        chk({15'h0, seen_busy}, rows[i].e, "busy");
    end
    run(cmd_read, 8'hff, 16'h0000, 4'h2);
    chk(16'({got[0], got[1]} == 32'h8001ffff), 16'h0001, "wrap");
    chk({15'h0, write_enabled}, 16'h0001, "enabled");
    run(cmd_write_disable, 8'h00, 16'h0000, 4'h0);
    run(cmd_write, 8'h00, 16'h3333, 4'h0);
    chk({14'h0, seen_busy, write_enabled}, 16'h0000, "disabled");
    run(cmd_read, 8'hff, 16'h0000, 4'h0);
    chk(got[0], 16'h8001, "read");
    run(cmd_write_enable, 8'h00, 16'h0000, 4'h0);
    auto_lock = 1'b1;
    run(cmd_write, 8'h10, 16'h5555, 4'h0);
    chk({15'h0, write_enabled}, 16'h0000, "lock");
    run(cmd_read, 8'h10, 16'h0000, 4'h0);
    chk(got[0], 16'h5555, "locked");
    end_sim();
  end
endmodule

`default_nettype wire
